// ---- head_offset_and_fault_logic_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module head_offset_and_fault_logic_tb;
   localparam int unsigned SC = 20;
   localparam int unsigned TC = 200;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, se;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic drive_selected, abnormal_condition, on_track, panel_fault_clear, ctl_fault_clear;
   logic seek_active, rtz_active, at_target, settling, track_crossing_pulse, sync_pulse;
   logic index_slot, index_present, valid_index, guard_band;
   logic read_gate, write_gate, index_check_err, multi_head_select_err, head_short_err;
   logic write_current_sense, write_current_control, current_delta_err, write_capability;
   logic unit_not_ready, track_follow_timer, access_check, read_only_mode;
   logic offset_plus, offset_minus, offset_outward_dir, offset_active, difference_sixteen;
   logic offset_edge_pulse, seek_end, on_cylinder, fault_line, seek_error;
   logic [3:0]  indicator_group_one, indicator_group_two, seek_display;
   logic [12:0] flt;
   logic [7:0]  ofs;
   int          err_count, checks_done, cyc;
   // row: 13 fault inputs (read gate first, read only last), then {group two, group one}
   localparam logic [20:0] ROWS [14] = '{
      21'h140001, 21'h040000,
      21'h180002, 21'h080102,
      21'h0A0004, 21'h110008,
      21'h108010, 21'h088010, 21'h08C000,
      21'h082040,
      21'h081880, 21'h081480, 21'h081280, 21'h080800};
   assign {read_gate, write_gate, index_check_err, multi_head_select_err, head_short_err,
           write_current_sense, write_current_control, current_delta_err, write_capability,
           unit_not_ready, track_follow_timer, access_check, read_only_mode} = flt;
   assign ofs = {offset_plus, offset_minus, offset_outward_dir, offset_active,
                 difference_sixteen, offset_edge_pulse, seek_end, on_cylinder};
   hof_top #(.SETTLE_CYC(SC), .TIMEOUT_CYC(TC)) u_hof_top (.clk, .arst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .drive_selected,
      .abnormal_condition, .on_track, .read_gate, .write_gate, .index_check_err,
      .multi_head_select_err, .head_short_err, .write_current_sense, .write_current_control,
      .current_delta_err, .write_capability, .unit_not_ready, .track_follow_timer,
      .access_check, .read_only_mode, .panel_fault_clear, .ctl_fault_clear, .seek_active,
      .rtz_active, .at_target, .settling, .track_crossing_pulse, .index_slot,
      .index_present, .sync_pulse, .offset_plus, .offset_minus,
      .offset_outward_dir, .offset_active, .difference_sixteen, .offset_edge_pulse,
      .seek_end, .on_cylinder, .fault_line, .indicator_group_one, .indicator_group_two,
      .seek_error, .seek_display, .valid_index, .guard_band);
   hof_ctl_model u_hof_ctl_model (.clk, .pready, .pslverr, .prdata, .psel, .penable,
      .pwrite, .paddr, .pwdata);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic results;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         results();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      u_hof_ctl_model.xfer(w, a, d, rd, se);
   endtask
   task automatic pulse_clr(input bit panel);
      @(posedge clk);
      if (panel) panel_fault_clear <= 1'b1;
      else ctl_fault_clear <= 1'b1;
      @(posedge clk);
      panel_fault_clear <= 1'b0;
      ctl_fault_clear <= 1'b0;
   endtask
   task automatic area(input logic [3:0] absent);
      for (int k = 3; k >= 0; k--) begin
         @(posedge clk);
         {index_slot, index_present} <= {1'b1, !absent[k]};
      end
      @(posedge clk);
      {index_slot, sync_pulse} <= 2'h1;
      @(posedge clk);
      sync_pulse <= 1'b0;
   endtask
   initial begin
      {arst_n, abnormal_condition, panel_fault_clear, ctl_fault_clear, seek_active} <= '0;
      {at_target, settling, track_crossing_pulse, flt} <= '0;
      {rtz_active, index_slot, index_present, sync_pulse} <= '0;
      {drive_selected, on_track} <= 2'h3;
      repeat (8) @(posedge clk);
      #1 `CHK("reset ofs", 8'h03, ofs)
      @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 14; i++) begin
         @(posedge clk);
         flt <= ROWS[i][20:8];
         @(posedge clk);
         flt <= '0;
         @(posedge clk);
         #1 `CHK("groups", ROWS[i][7:0], {indicator_group_two, indicator_group_one})
         `CHK("fault_line", |ROWS[i][7:0], fault_line)
         pulse_clr(i[0]);
         @(posedge clk);
         #1 `CHK("clr", 9'h000, {fault_line, indicator_group_two, indicator_group_one})
      end
      apb(1'b1, hof_pkg::ADDR_THIRD_TAG_COMMAND, 32'h4);
      @(posedge clk);
      #1 `CHK("plus on", 8'hBC, ofs)
      @(posedge clk);
      #1 `CHK("plus pulse", 8'hB8, ofs)
      repeat (SC - 2) @(posedge clk);
      #1 `CHK("plus settling", 8'hB8, ofs)
      @(posedge clk);
      #1 `CHK("plus settled", 8'hBB, ofs)
      flt <= 13'h0800;
      @(posedge clk);
      flt <= '0;
      @(posedge clk);
      #1 `CHK("wg offset", 4'h2, indicator_group_one)
      apb(1'b0, hof_pkg::ADDR_FAULT, 32'h0);
      `CHK("fault reg", 32'h102, rd)
      pulse_clr(1'b0);
      on_track <= 1'b0;
      apb(1'b1, hof_pkg::ADDR_THIRD_TAG_COMMAND, 32'h0);
      @(posedge clk);
      #1 `CHK("off", 8'h04, ofs)
      repeat (SC) @(posedge clk);
      #1 `CHK("off track end", 8'h02, ofs)
      @(posedge clk);
      on_track <= 1'b1;
      apb(1'b1, hof_pkg::ADDR_THIRD_TAG_COMMAND, 32'h8);
      @(posedge clk);
      #1 `CHK("minus on", 8'h5C, ofs)
      apb(1'b1, hof_pkg::ADDR_THIRD_TAG_COMMAND, 32'h0);
      repeat (SC + 2) @(posedge clk);
      abnormal_condition <= 1'b1;
      apb(1'b1, hof_pkg::ADDR_THIRD_TAG_COMMAND, 32'h4);
      @(posedge clk);
      #1 `CHK("abnormal", 8'hA3, ofs)
      @(posedge clk);
      drive_selected <= 1'b0;
      @(posedge clk);
      #1 `CHK("deselect", 8'h03, ofs)
      @(posedge clk);
      seek_active <= 1'b1;
      area(4'h3);
      #1 `CHK("igb1 vix", 1'b0, valid_index)
      @(posedge clk);
      #1 `CHK("guard", 5'h14, {guard_band, seek_display})
      `CHK("guard err", 1'b1, seek_error)
      seek_active <= 1'b0;
      area(4'h5);
      #1 `CHK("vix", 1'b1, valid_index)
      @(posedge clk);
      #1 `CHK("vix once", 1'b0, valid_index)
      rtz_active <= 1'b1;
      repeat (TC + 5) @(posedge clk);
      rtz_active <= 1'b0;
      apb(1'b0, hof_pkg::ADDR_SEEK, 32'h0);
      `CHK("seek reg", 5'h16, rd[4:0])
      apb(1'b1, hof_pkg::ADDR_SEEK_CLR, 32'h1);
      @(posedge clk);
      {settling, at_target} <= 2'h3;
      repeat (3) begin
         @(posedge clk);
         track_crossing_pulse <= 1'b1;
         @(posedge clk);
         track_crossing_pulse <= 1'b0;
      end
      @(posedge clk);
      #1 `CHK("overshoot", 5'h14, {seek_error, seek_display})
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 33'h100000000, {se, rd})
      results();
   end
endmodule

// ---- hof_ctl_model.sv ----
`timescale 1ns/1ps
module hof_ctl_model (
   input  wire logic        clk,     // logic clock
   input  wire logic        pready,  // apb ready
   input  wire logic        pslverr, // apb error
   input  wire logic [31:0] prdata,  // apb read data
   output logic             psel,    // apb select
   output logic             penable, // apb enable
   output logic             pwrite,  // apb direction
   output logic [7:0]       paddr,   // apb byte address
   output logic [31:0]      pwdata   // apb write data
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // only tag bits 2 and 3 and the clear word are ever sent
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data must not look like the last word
      pwdata <= ~wd;
   endtask
endmodule

// ---- hof_pattern_dec.sv ----
`timescale 1ns/1ps
module hof_pattern_dec (
   input  wire logic clk,           // logic clock
   input  wire logic arst_n,        // async reset
   input  wire logic index_slot,    // strobe at each index slot
   input  wire logic index_present, // index pulse seen in slot
   input  wire logic sync_pulse,    // sync pulse ending an area
   output logic      valid_index,   // track start pulse
   output logic      guard_ib1,     // inner guard band 1
   output logic      guard_ib2,     // inner guard band 2
   output logic      guard_ob       // outer guard band
);
   localparam int BW = $clog2(hof_pkg::GUARD_PERIOD);
   logic [hof_pkg::PAT_LEN-1:0] shift_q, shift_d;
   logic [BW-1:0]               byte_q, byte_d;
   logic                        valid_q, valid_d, ib1_q, ib1_d, ib2_q, ib2_d, ob_q, ob_d;
   logic                        vmatch, gslot;

   always_comb begin
      shift_d = shift_q;
      byte_d  = byte_q;
      vmatch  = (shift_q == hof_pkg::PAT_VALID);
      gslot   = sync_pulse && (byte_q == '0) && !vmatch;
      if (index_slot) begin
         shift_d = {shift_q[hof_pkg::PAT_LEN-2:0], !index_present}; // [RULE19]
      end
      if (sync_pulse) begin
         // valid pattern resyncs the 64-byte guard phase
         byte_d = vmatch ? BW'(1) : BW'(byte_q + 1'b1); // [RULE20]
      end
      valid_d = sync_pulse && vmatch; // [RULE21]
      ib1_d   = gslot && (shift_q == hof_pkg::PAT_IGB1); // [RULE20]
      ib2_d   = gslot && (shift_q == hof_pkg::PAT_IGB2);
      ob_d    = gslot && (shift_q == hof_pkg::PAT_OGB);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_q <= '0;
         byte_q  <= '0;
         valid_q <= 1'b0;
         ib1_q   <= 1'b0;
         ib2_q   <= 1'b0;
         ob_q    <= 1'b0;
      end else begin
         shift_q <= shift_d;
         byte_q  <= byte_d;
         valid_q <= valid_d;
         ib1_q   <= ib1_d;
         ib2_q   <= ib2_d;
         ob_q    <= ob_d;
      end
   end

   assign valid_index = valid_q;
   assign guard_ib1   = ib1_q;
   assign guard_ib2   = ib2_q;
   assign guard_ob    = ob_q;

   valid_over_guard_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE20]
      valid_q |-> !(ib1_q || ib2_q || ob_q))
      else $error("guard band reported with valid index");
endmodule

// ---- hof_pkg.sv ----
// Operation
// (RULE1) selected and tag bit 2 gives outward plus
// (RULE2) offset active only without abnormal condition; code checks this only at the request rise
// (RULE3) offset move settles within five milliseconds
// (RULE4) active rise: pulse, timer, drop seek end
// (RULE5) tag bit 3 gives minus, inward direction
// (RULE6) clearing offset bit drops all offset outputs
// (RULE7) active fall: pulse, timer, on track check
// (RULE8) any check condition sets fault line
// (RULE9) index check during gates sets bit 1
// (RULE10) conflicting gates set control check bit 2
// (RULE11) multi head bit 4, head short bit 8
// (RULE12) write current on read sets group two bit 1
// (RULE13) current delta during write sets bit 4
// (RULE14) servo off track sets group two bit 8
// (RULE15) panel or controller clear empties faults
// (RULE16) seek error sets latch, line and lamp
// (RULE17) seek timeout shows as display bit 2
// (RULE18) overshoot shows as display bit 4
// (RULE19) index slot present reads 0, absent 1
// (RULE20) guard bands every 64 bytes, valid wins
// (RULE21) valid index marks track start once
// (RULE22) seek over 250 ms is access timeout
// (RULE23) three crossings after target mean overshoot
// (RULE24) fault bits stay latched until cleared
package hof_pkg;
   localparam int unsigned CLK_MHZ         = 25;
   localparam int unsigned SETTLE_TIME_US  = 5000;
   localparam int unsigned SETTLE_CYC      = SETTLE_TIME_US * CLK_MHZ;
   localparam int unsigned TIMEOUT_TIME_MS = 250;
   localparam int unsigned TIMEOUT_CYC     = TIMEOUT_TIME_MS * 1000 * CLK_MHZ;
   localparam int          TMR_W           = 24;
   localparam logic [7:0]  ADDR_THIRD_TAG_COMMAND       = 8'h00;
   localparam logic [7:0]  ADDR_FAULT      = 8'h04;
   localparam logic [7:0]  ADDR_SEEK       = 8'h08;
   localparam logic [7:0]  ADDR_OFFS       = 8'h0C;
   localparam logic [7:0]  ADDR_SEEK_CLR   = 8'h10;
   localparam int          THIRD_TAG_COMMAND_PLUS_BIT   = 2;
   localparam int          THIRD_TAG_COMMAND_MINUS_BIT  = 3;
   localparam logic [1:0]  THIRD_TAG_COMMAND_RST        = 2'h0;
   localparam int          BIT1            = 0;
   localparam int          BIT2            = 1;
   localparam int          BIT4            = 2;
   localparam int          BIT8            = 3;
   localparam int          FAULT_G2_POS    = 4;
   localparam int          FAULT_LINE_POS  = 8;
   localparam int          SEEK_LATCH_POS  = 4;
   localparam logic [1:0]  OVERSHOOT_XINGS = 2'h3;
   localparam int          GUARD_PERIOD    = 64;
   localparam int          PAT_LEN         = 4;
   localparam logic [3:0]  PAT_VALID       = 4'h5;
   localparam logic [3:0]  PAT_IGB1        = 4'h3;
   localparam logic [3:0]  PAT_IGB2        = 4'h6;
   localparam logic [3:0]  PAT_OGB         = 4'hC;
endpackage

// ---- hof_top.sv ----
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module hof_top #(
   parameter int unsigned SETTLE_CYC  = hof_pkg::SETTLE_CYC,
   parameter int unsigned TIMEOUT_CYC = hof_pkg::TIMEOUT_CYC
) (
   input  wire logic        clk,                   // 25 MHz logic clock
   input  wire logic        arst_n,                // async reset
   input  wire logic        psel,                  // apb select
   input  wire logic        penable,               // apb enable
   input  wire logic        pwrite,                // apb direction
   input  wire logic [7:0]  paddr,                 // apb byte address
   input  wire logic [31:0] pwdata,                // apb write data
   output logic [31:0]      prdata,                // apb read data
   output logic             pready,                // apb ready
   output logic             pslverr,               // apb error
   input  wire logic        drive_selected,        // drive is selected
   input  wire logic        abnormal_condition,    // abnormal drive state
   input  wire logic        on_track,              // head on track
   input  wire logic        read_gate,             // read gate
   input  wire logic        write_gate,            // write gate
   input  wire logic        index_check_err,       // index check
   input  wire logic        multi_head_select_err, // multi head select
   input  wire logic        head_short_err,        // head short
   input  wire logic        write_current_sense,   // write current seen
   input  wire logic        write_current_control, // write current on
   input  wire logic        current_delta_err,     // write current delta
   input  wire logic        write_capability,      // write capable
   input  wire logic        unit_not_ready,        // unit not ready
   input  wire logic        track_follow_timer,    // track follow timer
   input  wire logic        access_check,          // access check
   input  wire logic        read_only_mode,        // read only
   input  wire logic        panel_fault_clear,     // panel clear switch
   input  wire logic        ctl_fault_clear,       // controller clear
   input  wire logic        seek_active,           // direct seek running
   input  wire logic        rtz_active,            // rezero seek running
   input  wire logic        at_target,             // target reached
   input  wire logic        settling,              // settling phase
   input  wire logic        track_crossing_pulse,  // track crossing
   input  wire logic        index_slot,            // index slot strobe
   input  wire logic        index_present,         // index pulse present
   input  wire logic        sync_pulse,            // sync pulse
   output logic             offset_plus,           // offset plus
   output logic             offset_minus,          // offset minus
   output logic             offset_outward_dir,    // outward direction
   output logic             offset_active,         // offset active
   output logic             difference_sixteen,    // servo offset drive
   output logic             offset_edge_pulse,     // active edge pulse
   output logic             seek_end,              // seek end
   output logic             on_cylinder,           // on cylinder
   output logic             fault_line,            // fault to controller
   output logic [3:0]       indicator_group_one,   // fault lamps 1
   output logic [3:0]       indicator_group_two,   // fault lamps 2
   output logic             seek_error,            // seek error line
   output logic [3:0]       seek_display,          // seek lamps
   output logic             valid_index,           // track start pulse
   output logic             guard_band             // any guard band
);
   // apb slave: no wait states, read data comes from a flop loaded in the setup cycle
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d, pslverr_q, pslverr_d;
   logic [1:0]  third_tag_command_q, third_tag_command_d;
   logic        setup, wr_en, seek_clr;

   // offset sequencer
   logic             plus_q, plus_d, minus_q, minus_d, out_q, out_d;
   logic             act_q, act_d, d16_q, d16_d, pulse_q, pulse_d;
   logic             timing_q, timing_d, fall_q, fall_d, send_q, send_d, on_cylinder_q, on_cylinder_d;
   logic [hof_pkg::TMR_W-1:0] tmr_q, tmr_d;
   logic             req_now, req_prev;

   // fault register
   logic [3:0] g1_q, g1_d, g2_q, g2_d, set1, set2;
   logic       fault_q, fault_d, rwg, fclr;

   // seek check
   logic [hof_pkg::TMR_W-1:0] to_q, to_d;
   logic [1:0] xing_q, xing_d;
   logic [3:0] sdisp_q, sdisp_d;
   logic       serr_q, serr_d, gb_q, gb_d;
   logic       vix, ib1, ib2, ob, gb_any;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == hof_pkg::ADDR_THIRD_TAG_COMMAND) || (a == hof_pkg::ADDR_FAULT) ||
               (a == hof_pkg::ADDR_SEEK) || (a == hof_pkg::ADDR_OFFS) ||
               (a == hof_pkg::ADDR_SEEK_CLR);
   endfunction

   hof_pattern_dec u_dec (
      .clk           (clk),
      .arst_n        (arst_n),
      .index_slot    (index_slot),
      .index_present (index_present),
      .sync_pulse    (sync_pulse),
      .valid_index   (vix),
      .guard_ib1     (ib1),
      .guard_ib2     (ib2),
      .guard_ob      (ob)
   );
   assign gb_any = ib1 || ib2 || ob;

   always_comb begin
      setup     = psel && !penable;
      wr_en     = psel && penable && pready_q && pwrite;
      pready_d  = setup;
      pslverr_d = setup && !mapped(paddr);
      prdata_d  = prdata_q;
      if (setup) begin
         prdata_d = 32'h0000_0000;
         if (!pwrite) begin
            case (paddr)
               hof_pkg::ADDR_THIRD_TAG_COMMAND: begin
                  prdata_d[hof_pkg::THIRD_TAG_COMMAND_PLUS_BIT]  = third_tag_command_q[0];
                  prdata_d[hof_pkg::THIRD_TAG_COMMAND_MINUS_BIT] = third_tag_command_q[1];
               end
               hof_pkg::ADDR_FAULT: begin
                  prdata_d[3:0] = g1_q;
                  prdata_d[hof_pkg::FAULT_G2_POS +: 4] = g2_q;
                  prdata_d[hof_pkg::FAULT_LINE_POS] = fault_q;
               end
               hof_pkg::ADDR_SEEK: begin
                  prdata_d[3:0] = sdisp_q;
                  prdata_d[hof_pkg::SEEK_LATCH_POS] = serr_q;
               end
               hof_pkg::ADDR_OFFS: begin
                  prdata_d[7:0] = {on_cylinder_q, send_q, pulse_q, d16_q, act_q, out_q, minus_q, plus_q};
               end
               default: begin
                  prdata_d = 32'h0000_0000;
               end
            endcase
         end
      end
      third_tag_command_d = third_tag_command_q;
      if (wr_en && paddr == hof_pkg::ADDR_THIRD_TAG_COMMAND) begin
         third_tag_command_d = {pwdata[hof_pkg::THIRD_TAG_COMMAND_MINUS_BIT], pwdata[hof_pkg::THIRD_TAG_COMMAND_PLUS_BIT]};
      end
      seek_clr = wr_en && (paddr == hof_pkg::ADDR_SEEK_CLR) && pwdata[0];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         third_tag_command_q    <= hof_pkg::THIRD_TAG_COMMAND_RST;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         third_tag_command_q    <= third_tag_command_d;
      end
   end

   always_comb begin
      plus_d   = drive_selected && third_tag_command_q[0]; // [RULE1]
      // plus wins if software sets both bits
      minus_d  = drive_selected && third_tag_command_q[1] && !third_tag_command_q[0]; // [RULE5]
      out_d    = plus_d; // [RULE1] [RULE5]
      req_now  = plus_d || minus_d;
      req_prev = plus_q || minus_q;
      act_d    = act_q;
      if (req_now && !req_prev && !abnormal_condition) begin
         act_d = 1'b1; // [RULE2]
      end
      if (!req_now) begin
         act_d = 1'b0; // [RULE6]
      end
      d16_d    = act_d; // [RULE2] [RULE6]
      pulse_d  = 1'b0;
      timing_d = timing_q;
      fall_d   = fall_q;
      tmr_d    = tmr_q;
      send_d   = send_q;
      on_cylinder_d  = on_cylinder_q;
      if (act_d != act_q) begin
         pulse_d  = 1'b1; // [RULE4] [RULE7]
         timing_d = 1'b1;
         fall_d   = !act_d;
         tmr_d    = hof_pkg::TMR_W'(SETTLE_CYC - 1); // [RULE3]
         send_d   = 1'b0;
         on_cylinder_d  = 1'b0;
      end else if (timing_q) begin
         if (tmr_q == '0) begin
            timing_d = 1'b0;
            send_d   = 1'b1; // [RULE4]
            on_cylinder_d  = fall_q ? on_track : 1'b1; // [RULE7]
         end else begin
            tmr_d = tmr_q - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         plus_q   <= 1'b0;
         minus_q  <= 1'b0;
         out_q    <= 1'b0;
         act_q    <= 1'b0;
         d16_q    <= 1'b0;
         pulse_q  <= 1'b0;
         timing_q <= 1'b0;
         fall_q   <= 1'b0;
         tmr_q    <= '0;
         send_q   <= 1'b1;
         on_cylinder_q  <= 1'b1;
      end else begin
         plus_q   <= plus_d;
         minus_q  <= minus_d;
         out_q    <= out_d;
         act_q    <= act_d;
         d16_q    <= d16_d;
         pulse_q  <= pulse_d;
         timing_q <= timing_d;
         fall_q   <= fall_d;
         tmr_q    <= tmr_d;
         send_q   <= send_d;
         on_cylinder_q  <= on_cylinder_d;
      end
   end

   always_comb begin
      rwg = read_gate || write_gate;
      set1 = 4'h0;
      set2 = 4'h0;
      set1[hof_pkg::BIT1] = rwg && index_check_err; // [RULE9]
      set1[hof_pkg::BIT2] = write_gate && (read_gate || act_q || read_only_mode); // [RULE10]
      set1[hof_pkg::BIT4] = rwg && multi_head_select_err; // [RULE11]
      set1[hof_pkg::BIT8] = rwg && head_short_err; // [RULE11]
      set2[hof_pkg::BIT1] = write_current_sense &&
                            (read_gate || (write_gate && !write_current_control)); // [RULE12]
      set2[hof_pkg::BIT4] = write_gate && current_delta_err; // [RULE13]
      set2[hof_pkg::BIT8] = write_gate && write_capability &&
                            (unit_not_ready || track_follow_timer || access_check); // [RULE14]
      fclr = panel_fault_clear || ctl_fault_clear; // [RULE15]
      // a new fault in the clearing cycle survives the clear
      g1_d = (fclr ? 4'h0 : g1_q) | set1; // [RULE24]
      g2_d = (fclr ? 4'h0 : g2_q) | set2; // [RULE24]
      fault_d = (|g1_d) || (|g2_d); // [RULE8]
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         g1_q    <= 4'h0;
         g2_q    <= 4'h0;
         fault_q <= 1'b0;
      end else begin
         g1_q    <= g1_d;
         g2_q    <= g2_d;
         fault_q <= fault_d;
      end
   end

   always_comb begin
      sdisp_d = seek_clr ? 4'h0 : sdisp_q;
      to_d    = '0;
      xing_d  = '0;
      if (seek_active || rtz_active) begin
         if (to_q == hof_pkg::TMR_W'(TIMEOUT_CYC - 1)) begin
            sdisp_d[hof_pkg::BIT2] = 1'b1; // [RULE17] [RULE22]
            to_d = to_q;
         end else begin
            to_d = to_q + 1'b1;
         end
      end
      if (seek_active && gb_any) begin
         sdisp_d[hof_pkg::BIT4] = 1'b1; // [RULE18]
      end
      if (settling && at_target) begin
         xing_d = xing_q;
         if (track_crossing_pulse && xing_q != hof_pkg::OVERSHOOT_XINGS) begin
            xing_d = xing_q + 1'b1;
         end
         if (xing_d == hof_pkg::OVERSHOOT_XINGS) begin
            sdisp_d[hof_pkg::BIT4] = 1'b1; // [RULE18] [RULE23]
         end
      end
      serr_d = |sdisp_d; // [RULE16]
      gb_d   = gb_any;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         to_q    <= '0;
         xing_q  <= '0;
         sdisp_q <= 4'h0;
         serr_q  <= 1'b0;
         gb_q    <= 1'b0;
      end else begin
         to_q    <= to_d;
         xing_q  <= xing_d;
         sdisp_q <= sdisp_d;
         serr_q  <= serr_d;
         gb_q    <= gb_d;
      end
   end

   assign prdata              = prdata_q;
   assign pready              = pready_q;
   assign pslverr             = pslverr_q;
   assign offset_plus         = plus_q;
   assign offset_minus        = minus_q;
   assign offset_outward_dir  = out_q;
   assign offset_active       = act_q;
   assign difference_sixteen  = d16_q;
   assign offset_edge_pulse   = pulse_q;
   assign seek_end            = send_q;
   assign on_cylinder         = on_cylinder_q;
   assign fault_line          = fault_q;
   assign indicator_group_one = g1_q;
   assign indicator_group_two = g2_q;
   assign seek_error          = serr_q;
   assign seek_display        = sdisp_q;
   assign valid_index         = vix;
   assign guard_band          = gb_q;

   plus_outward_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE1]
      (drive_selected && third_tag_command_q[0]) |=> (plus_q && out_q && !minus_q))
      else $error("plus offset not outward");
   minus_inward_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE5]
      (drive_selected && third_tag_command_q[1] && !third_tag_command_q[0]) |=> (minus_q && !out_q))
      else $error("minus offset not inward");
   abnormal_block_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE2]
      $rose(act_q) |-> (!$past(abnormal_condition) && d16_q))
      else $error("offset active despite abnormal");
   edge_pulse_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4]
      (act_q != $past(act_q)) |-> (pulse_q && !send_q && !on_cylinder_q && timing_q))
      else $error("offset edge without pulse");
   offset_drop_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE6]
      !(drive_selected && (third_tag_command_q != 2'h0))
      |=> (!act_q && !d16_q && !plus_q && !minus_q))
      else $error("offset outputs not dropped");
   settle_end_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE7]
      (timing_q && tmr_q == '0 && act_d == act_q)
      |=> (send_q && (on_cylinder_q == ($past(fall_q) ? $past(on_track) : 1'b1))))
      else $error("settle end outputs wrong");
   control_check_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
      (write_gate && read_only_mode) |=> (g1_q[hof_pkg::BIT2] && fault_q))
      else $error("control check not latched");
   fault_sticky_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE24]
      !fclr |=> (((g1_q & $past(g1_q)) == $past(g1_q)) &&
                 ((g2_q & $past(g2_q)) == $past(g2_q))))
      else $error("fault bit lost without clear");
   fault_clear_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE15]
      (fclr && !read_gate && !write_gate) |=> (g1_q == 4'h0 && g2_q == 4'h0 && !fault_q))
      else $error("fault clear ignored");
   timeout_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE22]
      ((seek_active || rtz_active) && to_q == hof_pkg::TMR_W'(TIMEOUT_CYC - 1) && !seek_clr)
      |=> (sdisp_q[hof_pkg::BIT2] && serr_q))
      else $error("seek timeout not flagged");
   overshoot_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE18]
      (seek_active && gb_any) |=> (sdisp_q[hof_pkg::BIT4] && serr_q))
      else $error("guard band overshoot missed");
endmodule
